// file: src/ccsr_core_state.sv
// Functional notes
// RULE_01: only priv handler, priv thread, user thread
// RULE_02: user access to restricted regs faults
// RULE_03: exception runs handler, else thread mode
// RULE_04: all sixteen core registers 32 bits
// RULE_05: r0-r7 all, r8-r12 32-bit only; code blocks only narrow writes to r8-r12
// RULE_06: r13 banked; process stack in user thread
// RULE_07: stack pointer low two bits zero
// RULE_08: subroutine call writes return address r14
// RULE_09: instruction pointer bit zero reads zero
// RULE_10: result flags in bits 27 to 31
// RULE_11: exception number in bits 0 to 8
// RULE_12: execution bits 10-15, 25-26, split access
// RULE_13: bit 24 reads one; clearing faults
// RULE_14: primary mask admits nmi and hard fault
// RULE_15: fault mask admits only nmi
// RULE_16: base priority blocks equal or higher
// RULE_17: control bit 0 selects thread privilege
// RULE_18: control bit 1 selects stack, zero in handler; code uses it in user thread only
// RULE_19: bit-band alias for sram region
// RULE_20: decode 4 GB address space into regions
// RULE_21: only compact instruction set executes
// RULE_22: unaligned data accesses supported
// RULE_23: reset: privileged thread, main stack, masks clear
//
// Chosen here: the strobed register port and the address map.
`include "ccsr_regs.svh"
`default_nettype none
module ccsr_core_state
	import ccsr_pkg::*;
#(
	parameter int PRIO_W = `CCSR_PRIORITY_THRESHOLD_MASK_W,
	parameter logic [31:0] SRAM_BASE = 32'h20000000,
	parameter logic [31:0] BAND_BASE = 32'h22000000
)
(
	input wire logic mclk_in, // cpu clock
	input wire logic rstn_in, // async reset, active low
	input wire ccsr_bus_s bus_in, // software register port
	input wire ccsr_core_s core_in, // call and exception events
	input wire logic narrow_instr_in, // access is a 16-bit encoding
	input wire logic wide_legacy_in, // legacy wide encoding seen
	input wire logic [8:0] irq_prio_in, // pending request priority
	input wire logic irq_is_nmi_in, // pending request is nmi
	input wire logic irq_is_hard_in, // pending request is hard fault
	input wire logic [31:0] data_addr_in, // data access address
	output logic [31:0] rdata_out, // read data, cycle after strobe
	output logic fault_out, // fault pulse
	output logic irq_admit_out, // pending request may be taken
	output logic [1:0] state_out, // execution state
	output logic [31:0] stack_ptr_out, // active stack pointer
	output logic [31:0] instr_pointer_out, // fetch address
	output logic [2:0] region_out, // region of data address
	output logic [31:0] band_addr_out, // alias word address
	output logic [4:0] band_bit_out // alias bit index
);
	// elaboration check: the threshold register holds at most nine bits
	if (PRIO_W < 1 || PRIO_W > 9)
	begin : g_prio_chk
		$error("priority width must be 1 to 9");
	end
	////////////////////////////////////////////////////////////////////
	logic [31:0] gpr_reg [0:12];
	logic [31:0] main_stack_ptr_reg, process_stack_ptr_reg;
	logic [31:0] return_link_reg, instr_pointer_reg;
	logic [31:0] flags_reg, exc_reg, exec_reg;
	logic primary_interrupt_mask_reg, fault_level_mask_reg;
	logic [PRIO_W-1:0] priority_threshold_mask_reg;
	logic [1:0] mode_control_reg;
	ccsr_state_e state_reg;
	logic [31:0] rdata_next;
	logic fault_next, user_lvl, restricted, wr_ok, use_psp;
	logic [4:0] a;

	// privileged-only check for a register index
	function automatic logic is_restricted(input logic [4:0] idx);
		is_restricted = idx >= `CCSR_IDX_EXCEPTION_NUMBER_STATUS;
	endfunction

	assign a = bus_in.addr;
	assign user_lvl = (state_reg == CCSR_USER_THREAD); // RULE_02
	assign restricted = is_restricted(a) && user_lvl; // RULE_02
	// high registers cannot be written by narrow encodings
	assign wr_ok = !restricted && !(narrow_instr_in && a >= 5'h08
		&& a <= `CCSR_IDX_GPR_LAST); // RULE_05
	assign use_psp = user_lvl && mode_control_reg[`CCSR_CTRL_PSTK]; // RULE_06
	////////////////////////////////////////////////////////////////////
	// execution state: handler while an exception runs, thread otherwise
	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			state_reg <= CCSR_PRIV_THREAD; // RULE_23
		else if (core_in.enter)
			state_reg <= CCSR_PRIV_HANDLER; // RULE_01 RULE_03
		else if (core_in.leave && state_reg == CCSR_PRIV_HANDLER)
			state_reg <= mode_control_reg[`CCSR_CTRL_USER] ?
				CCSR_USER_THREAD : CCSR_PRIV_THREAD; // RULE_03
		else if (state_reg != CCSR_PRIV_HANDLER)
			state_reg <= mode_control_reg[`CCSR_CTRL_USER] ?
				CCSR_USER_THREAD : CCSR_PRIV_THREAD; // RULE_17
	end
	////////////////////////////////////////////////////////////////////
	// control register; stack select forced low in handler mode
	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			mode_control_reg <= `CCSR_CTRL_RST; // RULE_23
		else if (bus_in.wr && a == `CCSR_IDX_CONTROL && wr_ok)
		begin
			mode_control_reg[`CCSR_CTRL_USER] <= bus_in.wdata[0]; // RULE_17
			// an entry in the same cycle must still leave the bit low
			mode_control_reg[`CCSR_CTRL_PSTK] <= bus_in.wdata[1]
				&& state_reg != CCSR_PRIV_HANDLER
				&& !core_in.enter; // RULE_18
		end
		else if (core_in.enter)
			mode_control_reg[`CCSR_CTRL_PSTK] <= 1'b0; // RULE_18
	end
	////////////////////////////////////////////////////////////////////
	// general purpose bank, no reset needed for data
	always_ff @(posedge mclk_in)
	begin
		if (bus_in.wr && a <= `CCSR_IDX_GPR_LAST && wr_ok) // RULE_05
			gpr_reg[a[3:0]] <= bus_in.wdata; // RULE_04
	end
	////////////////////////////////////////////////////////////////////
	// banked stack pointers, always word aligned
	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			main_stack_ptr_reg <= 32'h0;
			process_stack_ptr_reg <= 32'h0;
		end
		else if (bus_in.wr && wr_ok)
		begin
			if ((a == `CCSR_IDX_SP && !use_psp) || a == `CCSR_IDX_MSP)
				main_stack_ptr_reg <= {bus_in.wdata[31:2], 2'b00}; // RULE_07
			if ((a == `CCSR_IDX_SP && use_psp) || a == `CCSR_IDX_PSP)
				process_stack_ptr_reg <= {bus_in.wdata[31:2], 2'b00}; // RULE_06
		end
	end
	////////////////////////////////////////////////////////////////////
	// link register and instruction pointer
	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			return_link_reg <= 32'h0;
			instr_pointer_reg <= 32'h0;
		end
		else
		begin
			if (core_in.call)
				return_link_reg <= core_in.ret_addr; // RULE_08
			else if (bus_in.wr && a == `CCSR_IDX_LR && wr_ok)
				return_link_reg <= bus_in.wdata;
			if (bus_in.wr && a == `CCSR_IDX_PC && wr_ok)
				instr_pointer_reg <= {bus_in.wdata[31:1], 1'b0}; // RULE_09
		end
	end
	////////////////////////////////////////////////////////////////////
	// status portions; whole or separate access
	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			flags_reg <= 32'h0;
			exc_reg <= 32'h0;
			exec_reg <= `CCSR_PSR_RST;
		end
		else
		begin
			if (bus_in.wr && wr_ok &&
				(a == `CCSR_IDX_PSR || a == `CCSR_IDX_RESULT_FLAGS_STATUS))
				flags_reg <= bus_in.wdata & `CCSR_RESULT_FLAGS_STATUS_MASK; // RULE_10
			if (bus_in.wr && wr_ok &&
				(a == `CCSR_IDX_PSR || a == `CCSR_IDX_EXECUTION_STATE_STATUS))
				exec_reg <= (bus_in.wdata & `CCSR_EXECUTION_STATE_STATUS_MASK)
					| `CCSR_PSR_RST; // RULE_12 RULE_13
			// exception number is hardware owned
			if (core_in.enter)
				exc_reg <= {23'h0, core_in.exc_num}; // RULE_11
			else if (core_in.leave)
				exc_reg <= 32'h0;
		end
	end
	////////////////////////////////////////////////////////////////////
	// interrupt masking registers
	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			primary_interrupt_mask_reg <= 1'b0; // RULE_23
			fault_level_mask_reg <= 1'b0;
			priority_threshold_mask_reg <= '0;
		end
		else if (bus_in.wr && wr_ok)
		begin
			if (a == `CCSR_IDX_PRIMARY_INTERRUPT_MASK)
				primary_interrupt_mask_reg <= bus_in.wdata[0];
			if (a == `CCSR_IDX_FAULT_LEVEL_MASK)
				fault_level_mask_reg <= bus_in.wdata[0];
			if (a == `CCSR_IDX_PRIORITY_THRESHOLD_MASK)
				priority_threshold_mask_reg <= bus_in.wdata[PRIO_W-1:0];
		end
	end
	////////////////////////////////////////////////////////////////////
	// read mux
	always_comb
	begin
		rdata_next = 32'h0;
		if (a <= `CCSR_IDX_GPR_LAST)
			rdata_next = gpr_reg[a[3:0]];
		unique case (a)
			`CCSR_IDX_SP: rdata_next = use_psp ? process_stack_ptr_reg
				: main_stack_ptr_reg;
			`CCSR_IDX_LR: rdata_next = return_link_reg;
			`CCSR_IDX_PC: rdata_next = instr_pointer_reg;
			`CCSR_IDX_PSR: rdata_next = flags_reg | exc_reg | exec_reg;
			`CCSR_IDX_RESULT_FLAGS_STATUS: rdata_next = flags_reg;
			`CCSR_IDX_EXCEPTION_NUMBER_STATUS: rdata_next = exc_reg;
			`CCSR_IDX_EXECUTION_STATE_STATUS: rdata_next = exec_reg;
			`CCSR_IDX_PRIMARY_INTERRUPT_MASK: rdata_next = {31'h0, primary_interrupt_mask_reg};
			`CCSR_IDX_FAULT_LEVEL_MASK: rdata_next = {31'h0, fault_level_mask_reg};
			`CCSR_IDX_PRIORITY_THRESHOLD_MASK: rdata_next =
				32'(priority_threshold_mask_reg);
			`CCSR_IDX_CONTROL: rdata_next = {30'h0, mode_control_reg};
			`CCSR_IDX_MSP: rdata_next = main_stack_ptr_reg;
			`CCSR_IDX_PSP: rdata_next = process_stack_ptr_reg;
			`CCSR_IDX_STATE: rdata_next = {30'h0, state_reg};
			default: ;
		endcase
		if (restricted)
			rdata_next = 32'h0; // RULE_02
	end
	// fault on user access to restricted, clearing bit 24, legacy code
	always_comb
	begin
		fault_next = wide_legacy_in; // RULE_21
		if ((bus_in.wr || bus_in.rd) && restricted)
			fault_next = 1'b1; // RULE_02
		if (bus_in.wr && !bus_in.wdata[`CCSR_TBIT] &&
			(a == `CCSR_IDX_PSR || a == `CCSR_IDX_EXECUTION_STATE_STATUS))
			fault_next = 1'b1; // RULE_13
	end
	////////////////////////////////////////////////////////////////////
	// registered outputs
	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rdata_out <= 32'h0;
			fault_out <= 1'b0;
			irq_admit_out <= 1'b0;
			state_out <= 2'h0;
			stack_ptr_out <= 32'h0;
			instr_pointer_out <= 32'h0;
			region_out <= 3'h0;
			band_addr_out <= 32'h0;
			band_bit_out <= 5'h0;
		end
		else
		begin
			rdata_out <= bus_in.rd ? rdata_next : 32'h0;
			fault_out <= fault_next;
			// nmi always; hard fault unless fault mask; others by masks
			irq_admit_out <= irq_is_nmi_in ||
				(irq_is_hard_in && !fault_level_mask_reg) || // RULE_15
				(!primary_interrupt_mask_reg && !fault_level_mask_reg && // RULE_14
				(priority_threshold_mask_reg == '0 ||
				9'(irq_prio_in) < 9'(priority_threshold_mask_reg))); // RULE_16
			state_out <= state_reg;
			stack_ptr_out <= use_psp ? process_stack_ptr_reg
				: main_stack_ptr_reg; // RULE_06
			instr_pointer_out <= instr_pointer_reg;
			// 512 MB regions of the 4 GB space; unaligned addr passes
			region_out <= data_addr_in[31:29]; // RULE_20 RULE_22
			// alias word maps to one sram bit
			band_addr_out <= SRAM_BASE +
				{12'h0, data_addr_in[24:5]}; // RULE_19
			band_bit_out <= (data_addr_in[31:25] == BAND_BASE[31:25]) ?
				data_addr_in[4:0] : 5'h0; // RULE_19
		end
	end
endmodule
`default_nettype wire

// file: src/ccsr_pkg.sv
`default_nettype none
package ccsr_pkg;
	typedef enum logic [1:0]
	{
		CCSR_PRIV_THREAD = 2'b00,
		CCSR_USER_THREAD = 2'b01,
		CCSR_PRIV_HANDLER = 2'b10
	} ccsr_state_e;
	typedef struct packed
	{
		logic [4:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} ccsr_bus_s;
	typedef struct packed
	{
		logic call;
		logic [31:0] ret_addr;
		logic enter;
		logic [8:0] exc_num;
		logic leave;
	} ccsr_core_s;
endpackage
`default_nettype wire

// file: src/ccsr_regs.svh
`ifndef CCSR_REGS_SVH
`define CCSR_REGS_SVH
// register indices on the software port (word address, 5 bits)
`define CCSR_IDX_GPR_LAST 5'h0c
`define CCSR_IDX_SP 5'h0d
`define CCSR_IDX_LR 5'h0e
`define CCSR_IDX_PC 5'h0f
`define CCSR_IDX_PSR 5'h10
`define CCSR_IDX_RESULT_FLAGS_STATUS 5'h11
`define CCSR_IDX_EXCEPTION_NUMBER_STATUS 5'h12
`define CCSR_IDX_EXECUTION_STATE_STATUS 5'h13
`define CCSR_IDX_PRIMARY_INTERRUPT_MASK 5'h14
`define CCSR_IDX_FAULT_LEVEL_MASK 5'h15
`define CCSR_IDX_PRIORITY_THRESHOLD_MASK 5'h16
`define CCSR_IDX_CONTROL 5'h17
`define CCSR_IDX_MSP 5'h18
`define CCSR_IDX_PSP 5'h19
`define CCSR_IDX_STATE 5'h1a
// status field positions and masks
`define CCSR_RESULT_FLAGS_STATUS_MASK 32'hf8000000
`define CCSR_EXCEPTION_NUMBER_STATUS_MASK 32'h000001ff
`define CCSR_EXECUTION_STATE_STATUS_MASK 32'h0600fc00
`define CCSR_TBIT 24
`define CCSR_CTRL_USER 0
`define CCSR_CTRL_PSTK 1
// reset values and threshold register width
`define CCSR_CTRL_RST 2'h0
`define CCSR_PSR_RST 32'h01000000
`define CCSR_PRIORITY_THRESHOLD_MASK_W 9
`endif

// file: test/ccsr_core_state_sva.sv
`include "ccsr_regs.svh"
`default_nettype none
module ccsr_core_state_sva
	import ccsr_pkg::*;
(
	input wire logic mclk_in, // cpu clock
	input wire logic rstn_in, // async reset, active low
	input wire ccsr_bus_s bus_in, // register port
	input wire ccsr_core_s core_in, // core events
	input wire logic wide_legacy_in, // legacy encoding seen
	input wire logic irq_is_nmi_in, // nmi pending
	input wire logic [31:0] data_addr_in, // data address
	input wire logic [31:0] rdata_out, // read data
	input wire logic fault_out, // fault pulse
	input wire logic irq_admit_out, // admit level
	input wire logic [1:0] state_out, // execution state
	input wire logic [31:0] stack_ptr_out, // active stack pointer
	input wire logic [31:0] instr_pointer_out, // fetch address
	input wire logic [2:0] region_out // data region
);
	////////////////////////////////////////////////////////////////////////
	// one domain, so clock and reset are given once
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rstn_in);
	////////////////////////////////////////////////////////////////////////
	// alignment and state encoding hold in every cycle
	sp_word_align_a: assert property (stack_ptr_out[1:0] == 2'h0)
		else $error("stack pointer not word aligned");
	ip_half_align_a: assert property (!instr_pointer_out[0])
		else $error("fetch address not halfword aligned");
	state_legal_a: assert property (state_out != 2'h3)
		else $error("illegal execution state");
	// the user state lags one cycle, so a fresh exception entry is excluded
	user_block_a: assert property ((bus_in.rd || bus_in.wr)
		&& bus_in.addr >= `CCSR_IDX_EXCEPTION_NUMBER_STATUS && state_out == 2'h1
		&& !core_in.enter && !$past(core_in.enter) |=> fault_out)
		else $error("restricted access at user level did not fault");
	fault_cause_a: assert property (fault_out |-> $past(bus_in.wr)
		|| $past(bus_in.rd) || $past(wide_legacy_in))
		else $error("fault without a cause");
	enter_handler_a: assert property (core_in.enter && !core_in.leave
		|-> ##[1:3] state_out == CCSR_PRIV_HANDLER)
		else $error("exception did not enter handler mode");
	tbit_clear_a: assert property (bus_in.wr && bus_in.addr == `CCSR_IDX_PSR
		&& !bus_in.wdata[`CCSR_TBIT] |=> fault_out)
		else $error("clearing the compact bit did not fault");
	tbit_read_a: assert property (bus_in.rd && bus_in.addr == `CCSR_IDX_PSR
		|=> rdata_out[`CCSR_TBIT])
		else $error("compact bit read as zero");
	legacy_fault_a: assert property (wide_legacy_in |=> fault_out)
		else $error("legacy encoding did not fault");
	nmi_admit_a: assert property (irq_is_nmi_in |=> irq_admit_out)
		else $error("nmi not admitted");
	region_map_a: assert property (1'b1 |=> region_out == $past(data_addr_in[31:29]))
		else $error("region decode wrong");
endmodule
bind ccsr_core_state ccsr_core_state_sva ccsr_core_state_sva_inst (.mclk_in,
	.rstn_in, .bus_in, .core_in, .wide_legacy_in, .irq_is_nmi_in, .data_addr_in,
	.rdata_out, .fault_out, .irq_admit_out, .state_out, .stack_ptr_out,
	.instr_pointer_out, .region_out);
`default_nettype wire

// file: test/ccsr_core_state_test.sv
`include "ccsr_regs.svh"
`default_nettype none
module ccsr_core_state_test import ccsr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] SRAM = 32'h20000000;
	localparam logic [31:0] BAND = 32'h22000000;
	logic mclk_in = 1'b0;
	logic rstn_in = 1'b0;
	ccsr_bus_s bus = '0;
	ccsr_core_s core = '0;
	logic nar = 1'b0, leg = 1'b0, nmi = 1'b0, hard = 1'b0, f, flt, adm;
	logic [8:0] prio = 9'h0;
	logic [31:0] da = 32'h0, v, rd, sp, ip, ba;
	logic [1:0] st;
	logic [2:0] reg_o;
	logic [4:0] bb;
	int err_total = 0, n_compared = 0;
	logic [4:0] ri [6] = '{5'h17, 5'h14, 5'h15, 5'h16, 5'h10, 5'h1a};
	logic [31:0] re [6] = '{0, 0, 0, 0, 32'h01000000, 0};
	////////////////////////////////////////////////////////////////////////
	ccsr_core_state #(.SRAM_BASE(SRAM), .BAND_BASE(BAND)) ccsr_core_state_inst (
		.mclk_in(mclk_in), .rstn_in(rstn_in), .bus_in(bus), .core_in(core),
		.narrow_instr_in(nar), .wide_legacy_in(leg), .irq_prio_in(prio),
		.irq_is_nmi_in(nmi), .irq_is_hard_in(hard), .data_addr_in(da),
		.rdata_out(rd), .fault_out(flt), .irq_admit_out(adm), .state_out(st),
		.stack_ptr_out(sp), .instr_pointer_out(ip), .region_out(reg_o),
		.band_addr_out(ba), .band_bit_out(bb));
	// free running 100 MHz clock
	always #5 mclk_in = ~mclk_in;
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		if (seen !== exp)
		begin
			$display("BAD %s expected %h seen %h", nm, exp, seen);
			err_total++;
		end
		n_compared++;
	endtask
	// one strobe cycle; read data and fault are both valid one cycle later
	task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		bus <= '{a, d, w, !w};
		@(posedge mclk_in);
		bus <= '0;
		#1 v = rd;
		f = flt;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task automatic ev(input logic e, l, input logic [8:0] n);
		@(posedge mclk_in);
		core <= '{!e && !l, 32'hcafe0010, e, n, l};
		@(posedge mclk_in);
		core <= '0;
		tick(2);
	endtask
	task automatic mchk(input logic pm, fm, input logic [8:0] bp, pr,
		input logic n, h, e);
		acc(1, `CCSR_IDX_PRIMARY_INTERRUPT_MASK, {31'h0, pm});
		acc(1, `CCSR_IDX_FAULT_LEVEL_MASK, {31'h0, fm});
		acc(1, `CCSR_IDX_PRIORITY_THRESHOLD_MASK, {23'h0, bp});
		@(posedge mclk_in);
		prio <= pr;
		nmi <= n;
		hard <= h;
		tick(2);
		chk("admit", {31'h0, adm}, {31'h0, e});
	endtask
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// main sequence, one test after another
	initial
	begin
		repeat (3) @(posedge mclk_in);
		rstn_in <= 1'b1;
		foreach (ri[i])
		begin
			acc(0, ri[i], 0);
			chk("reset", v, re[i]);
		end
		acc(1, 5'h00, 32'ha5a55a5a);
		acc(1, 5'h08, 32'h11);
		acc(1, `CCSR_IDX_GPR_LAST, 32'hffffffff);
		nar <= 1'b1;
		acc(1, 5'h08, 32'h22);
		acc(1, 5'h07, 32'h77);
		nar <= 1'b0;
		acc(0, 5'h00, 0);
		chk("r0", v, 32'ha5a55a5a);
		acc(0, `CCSR_IDX_GPR_LAST, 0);
		chk("r12", v, 32'hffffffff);
		acc(0, 5'h08, 0);
		chk("r8", v, 32'h11);
		acc(0, 5'h07, 0);
		chk("r7", v, 32'h77);
		$display("test registers done");
		acc(1, `CCSR_IDX_SP, 32'hffffffff);
		acc(1, `CCSR_IDX_PC, 32'h1235);
		acc(0, `CCSR_IDX_SP, 0);
		chk("sp", v, 32'hfffffffc);
		chk("sp out", sp, 32'hfffffffc);
		acc(0, `CCSR_IDX_PC, 0);
		chk("pc", v, 32'h1234);
		chk("ip out", ip, 32'h1234);
		ev(0, 0, 9'h0);
		acc(0, `CCSR_IDX_LR, 0);
		chk("link", v, 32'hcafe0010);
		$display("test pointers done");
		acc(1, `CCSR_IDX_PSR, 32'hffffffff);
		chk("psr fault", f, 0);
		acc(0, `CCSR_IDX_RESULT_FLAGS_STATUS, 0);
		chk("flags", v, 32'hf8000000);
		acc(0, `CCSR_IDX_EXECUTION_STATE_STATUS, 0);
		chk("exec", v, 32'h0700fc00);
		acc(1, `CCSR_IDX_PSR, 0);
		chk("tbit fault", f, 1);
		acc(0, `CCSR_IDX_PSR, 0);
		chk("psr", v, 32'h01000000);
		ev(1, 0, 9'h1ab);
		chk("handler", st, 2);
		acc(0, `CCSR_IDX_EXCEPTION_NUMBER_STATUS, 0);
		chk("excnum", v, 32'h1ab);
		acc(1, `CCSR_IDX_CONTROL, 2);
		acc(0, `CCSR_IDX_CONTROL, 0);
		chk("ctrl hnd", v, 0);
		ev(0, 1, 9'h0);
		chk("thread", st, 0);
		acc(0, `CCSR_IDX_EXCEPTION_NUMBER_STATUS, 0);
		chk("excnum clr", v, 0);
		$display("test status done");
		mchk(0, 0, 9'h0, 9'h10, 0, 0, 1);
		mchk(1, 0, 9'h0, 9'h10, 0, 0, 0);
		mchk(1, 0, 9'h0, 9'h10, 0, 1, 1);
		mchk(0, 1, 9'h0, 9'h10, 0, 1, 0);
		mchk(0, 1, 9'h0, 9'h10, 1, 0, 1);
		mchk(0, 0, 9'h20, 9'h20, 0, 0, 0);
		mchk(0, 0, 9'h20, 9'h1f, 0, 0, 1);
		mchk(0, 0, 9'h0, 9'h0, 0, 0, 1);
		$display("test masks done");
		@(posedge mclk_in);
		da <= BAND + 32'h64;
		leg <= 1'b1;
		@(posedge mclk_in);
		leg <= 1'b0;
		#1 chk("legacy", flt, 1);
		tick(1);
		chk("band addr", ba, SRAM + 32'h3);
		chk("band bit", {27'h0, bb}, 32'h4);
		chk("region", {29'h0, reg_o}, 32'h1);
		$display("test decode done");
		acc(1, `CCSR_IDX_MSP, 32'h100);
		acc(1, `CCSR_IDX_PSP, 32'h200);
		acc(1, `CCSR_IDX_CONTROL, 3);
		tick(3);
		chk("user", st, 1);
		chk("psp", sp, 32'h200);
		acc(0, `CCSR_IDX_PRIMARY_INTERRUPT_MASK, 0);
		chk("blocked", v, 0);
		chk("user fault", f, 1);
		ev(1, 0, 9'h3);
		chk("user exc", st, 2);
		chk("msp", sp, 32'h100);
		ev(0, 1, 9'h0);
		chk("user back", st, 1);
		$display("test privilege done");
		stop_test;
	end
	// watchdog well beyond the length of the sequence
	initial
	begin
		repeat (20000) @(posedge mclk_in);
		err_total++;
		stop_test;
	end
endmodule
`default_nettype wire
